// >>> rtl/dram_ctl_cfg.svh
// dram_ctl_cfg.svh: register map, field positions, reset values and counts
// for the two-channel dram control block; definitions only.
`ifndef DRAM_CTL_CFG_SVH
`define DRAM_CTL_CFG_SVH

// register indexes; byte address is four times the index
`define IDX_CH0_LO   10'h160
`define IDX_CH0_HI   10'h161
`define IDX_CH1_LO   10'h162
`define IDX_CH1_HI   10'h163
`define IDX_CH0_REF  10'h164
`define IDX_CH1_REF  10'h165

// control low fields
`define LO_SELF_REF  7
`define LO_BUS_REL   5
`define LO_MUX_EN    3
`define LO_MUX_W     1
`define LO_ACC_EN    0
`define LO_MASK      8'hAF
`define LO_RESET     8'h80

// control high fields
`define HI_WR_WAIT   6
`define HI_RD_WAIT   4
`define HI_PAGE_EN   3
`define HI_MASK      8'hF8
`define HI_RESET     8'hA0

// refresh control fields
`define RF_DUMMY     7
`define RF_INTERVAL  4
`define RF_WIDTH     1
`define RF_INSERT    0
`define RF_RESET     8'h00

// dummy refresh cycles issued when the dummy bit is raised
`define DUMMY_COUNT  4'h8

`endif

// >>> rtl/dram_ctl_pkg.sv
// dram_ctl_pkg: types and decode functions shared by the dram control files.
// assumes dram_ctl_cfg.svh sits on the include path.
`include "dram_ctl_cfg.svh"

package dram_ctl_pkg;

  typedef enum logic [1:0] {SEL_NONE, SEL_LO, SEL_HI, SEL_REF} reg_sel_t;
  typedef enum logic [2:0] {ST_IDLE, ST_ROW, ST_COL, ST_OPEN, ST_REF, ST_SELF} seq_state_t;

  // refresh interval in clock states for each code
  function automatic logic [8:0] interval_states(input logic [2:0] code);
    case (code)
      3'h0:    interval_states = 9'd78;
      3'h1:    interval_states = 9'd154;
      3'h2:    interval_states = 9'd188;
      3'h3:    interval_states = 9'd226;
      3'h4:    interval_states = 9'd246;
      3'h5:    interval_states = 9'd302;
      3'h6:    interval_states = 9'd308;
      default: interval_states = 9'd384;
    endcase
  endfunction : interval_states

  // page wait code to extra cycles; reserved codes take the slow setting
  function automatic logic [3:0] page_waits(input logic [1:0] code);
    page_waits = (code == 2'h1) ? 4'h1 : 4'h2;
  endfunction : page_waits

endpackage : dram_ctl_pkg

// >>> rtl/dram_refresh_timer.sv
// dram_refresh_timer: per-channel refresh interval counter and request flag.
// assumes the sequencer pulses ref_ack once per refresh it starts.
`timescale 1ns/100ps
`default_nettype none

module dram_refresh_timer
  import dram_ctl_pkg::*;
(
  input  wire logic       pclk,         // system clock
  input  wire logic       presetn,      // async reset, active low
  input  wire logic       insert_en,    // periodic refresh enabled
  input  wire logic       dummy_en,     // dummy refresh bit
  input  wire logic [2:0] interval_sel, // interval code
  input  wire logic       ref_ack,      // refresh started
  output var  logic       ref_req       // refresh wanted
);

  logic [8:0] cnt_q,   cnt_d;
  logic       pend_q,  pend_d;
  logic       dm_q,    dm_d;
  logic [3:0] dummy_q, dummy_d;
  logic       tick;

  // interval count; a tick that meets an ack keeps the request alive
  always_comb begin
    tick    = insert_en && (cnt_q == interval_states(interval_sel) - 9'd1);
    cnt_d   = (!insert_en || tick) ? 9'h000 : cnt_q + 9'd1;
    dm_d    = dummy_en;
    dummy_d = dummy_q;
    if (dummy_en && !dm_q) begin
      dummy_d = `DUMMY_COUNT;
    end else if (ref_ack && dummy_q != 4'h0) begin
      dummy_d = dummy_q - 4'h1;
    end
    pend_d = (pend_q && !ref_ack) || tick || (dummy_d != 4'h0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= 9'h000;
      pend_q  <= 1'b0;
      dm_q    <= 1'b0;
      dummy_q <= 4'h0;
    end else begin
      cnt_q   <= cnt_d;
      pend_q  <= pend_d;
      dm_q    <= dm_d;
      dummy_q <= dummy_d;
    end
  end

  assign ref_req = pend_q;

endmodule : dram_refresh_timer

`default_nettype wire

// >>> rtl/dram_channel_seq.sv
// dram_channel_seq: one channel's access, page and refresh sequencer.
// assumes the requester holds req, we and addr until it sees ack.
`timescale 1ns/100ps
`default_nettype none

module dram_channel_seq
  import dram_ctl_pkg::*;
(
  input  wire logic        pclk,        // system clock
  input  wire logic        presetn,     // async reset, active low
  input  wire logic        self_rel,    // 1 releases self-refresh
  input  wire logic        hold,        // interface released to bus master
  input  wire logic        acc_en,      // accesses enabled
  input  wire logic        page_en,     // page mode enabled
  input  wire logic [1:0]  wr_wait,     // page write wait code
  input  wire logic [1:0]  rd_wait,     // page read wait code
  input  wire logic        mux_en,      // row/column multiplex on
  input  wire logic [1:0]  mux_w,       // column address width code
  input  wire logic [2:0]  ref_width,   // refresh width code
  input  wire logic        ref_req,     // refresh wanted
  input  wire logic        req,         // access request
  input  wire logic        we,          // access is a write
  input  wire logic [22:0] addr,        // access address
  output var  logic        ref_ack,     // refresh started, one cycle
  output var  logic        ack,         // access done, one cycle
  output var  logic        ras_n,       // row strobe
  output var  logic        cas_n,       // column strobe
  output var  logic        we_n,        // write strobe
  output var  logic [10:0] dram_addr,   // address pins
  output var  logic        self_active  // in self-refresh
);

  seq_state_t  st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic        ras_q, ras_d, cas_q, cas_d, we_q, we_d, ack_q, ack_d, rack_q, rack_d;
  logic [10:0] a_q, a_d;
  logic [22:0] row_q, row_d;
  logic [3:0]  cols;
  logic [10:0] row_a, col_a;
  logic        take;
  logic        self_q, self_d;

  // address split; multiplexing only when enabled
  always_comb begin
    cols  = 4'h8 + {2'b00, mux_w};
    row_a = mux_en ? 11'(addr >> cols) : addr[10:0];
    col_a = mux_en ? (addr[10:0] & (11'h7FF >> (2'h3 - mux_w))) : addr[10:0];
    take  = req && acc_en && !hold && !ack_q;
  end

  // next state; refresh and self-refresh win over new accesses
  always_comb begin
    st_d = st_q; cnt_d = cnt_q; ras_d = ras_q; cas_d = cas_q; we_d = we_q;
    a_d = a_q; row_d = row_q; ack_d = 1'b0; rack_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (!self_rel) begin
          st_d = ST_SELF; ras_d = 1'b0; cas_d = 1'b0;
        end else if (ref_req) begin
          st_d = ST_REF; ras_d = 1'b0; cas_d = 1'b0; rack_d = 1'b1;
          cnt_d = {1'b0, ref_width} + 4'h1;
        end else if (take) begin
          st_d = ST_ROW; ras_d = 1'b0; a_d = row_a; we_d = !we; row_d = addr;
        end
      end
      ST_ROW: begin
        st_d = ST_COL; cas_d = 1'b0; a_d = col_a;
        cnt_d = page_waits(we_q ? rd_wait : wr_wait);
      end
      ST_COL: begin
        if (cnt_q == 4'h0) begin
          ack_d = 1'b1; cas_d = 1'b1; we_d = 1'b1;
          if (page_en) st_d = ST_OPEN;
          else begin st_d = ST_IDLE; ras_d = 1'b1; end
        end else cnt_d = cnt_q - 4'h1;
      end
      ST_OPEN: begin
        if (ref_req || !self_rel || hold || !page_en || !acc_en) begin
          st_d = ST_IDLE; ras_d = 1'b1;
        end else if (take) begin
          if ((addr >> cols) == (row_q >> cols)) begin
            st_d = ST_COL; cas_d = 1'b0; a_d = col_a; we_d = !we; row_d = addr;
            cnt_d = page_waits(we ? wr_wait : rd_wait);
          end else begin
            st_d = ST_IDLE; ras_d = 1'b1;
          end
        end
      end
      ST_REF: begin
        if (cnt_q == 4'h0) begin st_d = ST_IDLE; ras_d = 1'b1; cas_d = 1'b1; end
        else cnt_d = cnt_q - 4'h1;
      end
      default: begin
        if (self_rel) begin st_d = ST_IDLE; ras_d = 1'b1; cas_d = 1'b1; end
      end
    endcase
    // registered decode so the status pin comes straight from a flop
    self_d = (st_d == ST_SELF);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE; cnt_q <= 4'h0; ras_q <= 1'b1; cas_q <= 1'b1; we_q <= 1'b1;
      a_q <= 11'h000; row_q <= 23'h000000; ack_q <= 1'b0; rack_q <= 1'b0;
      self_q <= 1'b0;
    end else begin
      st_q <= st_d; cnt_q <= cnt_d; ras_q <= ras_d; cas_q <= cas_d; we_q <= we_d;
      a_q <= a_d; row_q <= row_d; ack_q <= ack_d; rack_q <= rack_d;
      self_q <= self_d;
    end
  end

  assign ref_ack     = rack_q;
  assign ack         = ack_q;
  assign ras_n       = ras_q;
  assign cas_n       = cas_q;
  assign we_n        = we_q;
  assign dram_addr   = a_q;
  assign self_active = self_q;

endmodule : dram_channel_seq

`default_nettype wire

// >>> rtl/dram_ctl_top.sv
// dram_ctl_top: two-channel dram control block with its apb register file.
// assumes an apb master on pclk and requesters on the same clock.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none

module dram_ctl_top
  import dram_ctl_pkg::*;
(
  input  wire logic             pclk,            // system clock, 250 MHz
  input  wire logic             presetn,         // async reset, active low
  input  wire logic             psel,            // apb select
  input  wire logic             penable,         // apb access phase
  input  wire logic             pwrite,          // apb write
  input  wire logic [11:0]      paddr,           // apb byte address
  input  wire logic [31:0]      pwdata,          // apb write data
  output var  logic [31:0]      prdata,          // apb read data
  output var  logic             pready,          // apb ready
  output var  logic             pslverr,         // apb error, unmapped
  input  wire logic             bus_release_req, // external bus granted away
  input  wire logic [1:0]       mem_req,         // access request per channel
  input  wire logic [1:0]       mem_we,          // write access per channel
  input  wire logic [1:0][22:0] mem_addr,        // access address per channel
  output var  logic [1:0]       mem_ack,         // access done pulse
  output var  logic [1:0]       dram_ras_n,      // row strobe
  output var  logic [1:0]       dram_cas_n,      // column strobe
  output var  logic [1:0]       dram_we_n,       // write strobe
  output var  logic [1:0][10:0] dram_addr,       // multiplexed address
  output var  logic [1:0]       dram_released,   // interface floated
  output var  logic [1:0]       self_refresh_on  // channel in self-refresh
);

  // ************************************************************
  // address decode
  // ************************************************************

  // map a byte address to a register kind and channel
  function automatic reg_sel_t decode(input logic [11:0] a, output logic ch);
    logic [9:0] idx;
    idx = a[11:2];
    ch  = 1'b0;
    decode = SEL_NONE;
    if (a[1:0] != 2'h0) begin
      decode = SEL_NONE;
    end else if (idx == `IDX_CH0_LO) begin
      decode = SEL_LO;
    end else if (idx == `IDX_CH1_LO) begin
      decode = SEL_LO; ch = 1'b1;
    end else if (idx == `IDX_CH0_HI) begin
      decode = SEL_HI;
    end else if (idx == `IDX_CH1_HI) begin
      decode = SEL_HI; ch = 1'b1;
    end else if (idx == `IDX_CH0_REF) begin
      decode = SEL_REF;
    end else if (idx == `IDX_CH1_REF) begin
      decode = SEL_REF; ch = 1'b1;
    end
  endfunction : decode

  // ************************************************************
  // apb slave
  // ************************************************************

  logic [7:0]  lo_q  [2];
  logic [7:0]  lo_d  [2];
  logic [7:0]  hi_q  [2];
  logic [7:0]  hi_d  [2];
  logic [7:0]  ref_q [2];
  logic [7:0]  ref_d [2];
  logic [31:0] rdata_q, rdata_d;
  logic        ready_q, ready_d;
  logic        err_q,   err_d;
  reg_sel_t    sel;
  logic        sel_ch;
  logic        wr_now;

  // answer one cycle after setup; writes land at the accepting edge
  always_comb begin
    sel     = decode(paddr, sel_ch);
    ready_d = psel && !penable;
    err_d   = psel && !penable && (sel == SEL_NONE);
    rdata_d = rdata_q;
    wr_now  = psel && penable && ready_q && pwrite && !err_q;
    if (psel && !penable) begin
      // write-only refresh registers read back zero
      if (sel == SEL_LO) begin
        rdata_d = {24'h000000, lo_q[sel_ch]};
      end else if (sel == SEL_HI) begin
        rdata_d = {24'h000000, hi_q[sel_ch]};
      end else begin
        rdata_d = 32'h00000000;
      end
    end
    for (int c = 0; c < 2; c++) begin
      lo_d[c]  = lo_q[c];
      hi_d[c]  = hi_q[c];
      ref_d[c] = ref_q[c];
      if (wr_now && sel_ch == c[0]) begin
        if (sel == SEL_LO) begin
          lo_d[c] = pwdata[7:0] & `LO_MASK;
        end else if (sel == SEL_HI) begin
          hi_d[c] = pwdata[7:0] & `HI_MASK;
        end else if (sel == SEL_REF) begin
          ref_d[c] = pwdata[7:0];
        end
      end
    end
  end

  // register file; reset values put self-refresh released, all else idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++) begin
        lo_q[c]  <= `LO_RESET;
        hi_q[c]  <= `HI_RESET;
        ref_q[c] <= `RF_RESET;
      end
      rdata_q <= 32'h00000000;
      ready_q <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        lo_q[c]  <= lo_d[c];
        hi_q[c]  <= hi_d[c];
        ref_q[c] <= ref_d[c];
      end
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q   <= err_d;
    end
  end

  assign prdata  = rdata_q;
  assign pready  = ready_q;
  assign pslverr = err_q;

  // ************************************************************
  // channels
  // ************************************************************

  logic [1:0] rel_q, rel_d;

  // bus release floats the interface unless the channel keeps it
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      rel_d[c] = bus_release_req && !lo_q[c][`LO_BUS_REL];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_q <= 2'b00;
    end else begin
      rel_q <= rel_d;
    end
  end

  assign dram_released = rel_q;

  // identical channels; each has its own timer and sequencer
  for (genvar g = 0; g < 2; g++) begin : g_ch
    logic ref_req;
    logic ref_ack;

    dram_refresh_timer u_timer (
      .pclk         (pclk),
      .presetn      (presetn),
      .insert_en    (ref_q[g][`RF_INSERT]),
      .dummy_en     (ref_q[g][`RF_DUMMY]),
      .interval_sel (ref_q[g][`RF_INTERVAL +: 3]),
      .ref_ack      (ref_ack),
      .ref_req      (ref_req)
    );

    dram_channel_seq u_seq (
      .pclk        (pclk),
      .presetn     (presetn),
      .self_rel    (lo_q[g][`LO_SELF_REF]),
      .hold        (rel_q[g]),
      .acc_en      (lo_q[g][`LO_ACC_EN]),
      .page_en     (hi_q[g][`HI_PAGE_EN]),
      .wr_wait     (hi_q[g][`HI_WR_WAIT +: 2]),
      .rd_wait     (hi_q[g][`HI_RD_WAIT +: 2]),
      .mux_en      (lo_q[g][`LO_MUX_EN]),
      .mux_w       (lo_q[g][`LO_MUX_W +: 2]),
      .ref_width   (ref_q[g][`RF_WIDTH +: 3]),
      .ref_req     (ref_req),
      .req         (mem_req[g]),
      .we          (mem_we[g]),
      .addr        (mem_addr[g]),
      .ref_ack     (ref_ack),
      .ack         (mem_ack[g]),
      .ras_n       (dram_ras_n[g]),
      .cas_n       (dram_cas_n[g]),
      .we_n        (dram_we_n[g]),
      .dram_addr   (dram_addr[g]),
      .self_active (self_refresh_on[g])
    );
  end

endmodule : dram_ctl_top

`default_nettype wire

// >>> tb/dram_dev_model.sv
// dram_dev_model: behavioural dram device for one channel of the block.
// assumes registered active-low strobes on the same clock as the block.
`timescale 1ns/100ps
`default_nettype none

module dram_dev_model (
  input  wire logic        pclk,    // system clock
  input  wire logic        presetn, // reset, active low
  input  wire logic        ras_n,   // row strobe
  input  wire logic        cas_n,   // column strobe
  input  wire logic        we_n,    // write strobe
  input  wire logic [10:0] addr,    // address pins
  output var  logic [10:0] row,     // last row latched
  output var  logic [10:0] col,     // last column latched
  output var  logic        wr,      // last access was a write
  output var  int          n_ref,   // refresh cycles seen
  output var  int          gap,     // states between last two refreshes
  output var  int          width    // states of last refresh pulse
);
  logic ras_q;
  logic cas_q;
  logic in_ref;
  int   cnt;
  int   wcnt;

  // latch row and column like a real part; row and column falling in the same state mark a refresh
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ras_q, cas_q, in_ref, wr} <= 4'hC;
      {row, col} <= '0;
      {n_ref, gap, width, cnt, wcnt} <= '0;
    end else begin
      ras_q <= ras_n;
      cas_q <= cas_n;
      cnt <= cnt + 1;
      if (!ras_n && !cas_n && ras_q && cas_q) begin
        n_ref <= n_ref + 1;
        gap <= cnt;
        cnt <= 1;
        in_ref <= 1'b1;
        wcnt <= 1;
      end else if (in_ref) begin
        wcnt <= wcnt + (cas_n ? 0 : 1);
        width <= cas_n ? wcnt : width;
        in_ref <= !cas_n;
      end
      if (!ras_n && ras_q && cas_n) begin
        row <= addr;
      end
      if (!cas_n && cas_q && !ras_q) begin
        col <= addr;
        wr <= !we_n;
      end
    end
  end
endmodule : dram_dev_model

`default_nettype wire

// >>> tb/dram_ctl_sva.sv
// dram_ctl_sva: concurrent checks on the ports of the dram control block.
// assumes it is bound into dram_ctl_top, one clock pclk.
`timescale 1ns/100ps
`default_nettype none

module dram_ctl_sva (
  input wire logic        pclk,            // system clock
  input wire logic        presetn,         // reset, active low
  input wire logic        psel,            // apb select
  input wire logic        penable,         // apb access phase
  input wire logic [11:0] paddr,           // apb byte address
  input wire logic        pready,          // apb ready
  input wire logic        pslverr,         // apb error
  input wire logic        bus_release_req, // bus granted away
  input wire logic [1:0]  mem_req,         // access request
  input wire logic [1:0]  mem_ack,         // access done
  input wire logic [1:0]  dram_ras_n,      // row strobe
  input wire logic [1:0]  dram_cas_n,      // column strobe
  input wire logic [1:0]  dram_released,   // interface floated
  input wire logic [1:0]  self_refresh_on  // in self-refresh
);
  logic acc_q;
  logic hit_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // decode of a completing access, kept apart to keep the properties short
  assign acc_q = psel && penable && pready;
  assign hit_q = paddr inside {[12'h580:12'h594]} && paddr[1:0] == 2'b00;

  // ***************************************************************
  // checks
  // ***************************************************************
  a_ready_setup: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  a_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single cycle");
  a_err_unmapped: assert property (acc_q && !hit_q |-> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (acc_q && hit_q |-> !pslverr)
    else $error("error on mapped address");
  a_release_cause: assert property (!bus_release_req |=> dram_released == 2'b00)
    else $error("released without bus release");
  a_ack_pulse: assert property (mem_ack[0] |=> !mem_ack[0])
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (mem_ack[1] |-> $past(mem_req[1], 3) && $past(mem_req[1]))
    else $error("ack without held request");
  a_self_quiet: assert property (self_refresh_on[0] |-> !mem_ack[0])
    else $error("access done in self-refresh");
  a_cas_after_ras: assert property ($fell(dram_cas_n[0]) |-> !dram_ras_n[0])
    else $error("column strobe without row strobe");
  a_ref_min_width: assert property ($fell(dram_cas_n[1]) && $fell(dram_ras_n[1])
    |=> !dram_cas_n[1] && !dram_ras_n[1])
    else $error("refresh pulse under two states");

  // main scenarios reached
  c_ack: cover property (mem_ack[0]);
  c_err: cover property (acc_q && pslverr);
  c_self: cover property (self_refresh_on[0]);
  c_rel: cover property (dram_released[0]);
endmodule : dram_ctl_sva

`default_nettype wire

// >>> tb/dual_channel_dram_control_bench.sv
// dual_channel_dram_control_bench: self-checking bench for dram_ctl_top.
// assumes the package and cfg header are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "dram_ctl_cfg.svh"

module dual_channel_dram_control_bench;
  import dram_ctl_pkg::*;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_release_req, er;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic [1:0]       mem_req, mem_we, mem_ack, dram_ras_n, dram_cas_n, dram_we_n, dram_released, self_refresh_on;
  logic [1:0][22:0] mem_addr;
  logic [1:0][10:0] dram_addr;
  logic [10:0]      m_row [2];
  logic [10:0]      m_col [2];
  logic             m_wr [2];
  int               n_ref [2], gap [2], width [2];
  int               err_count, n_checks, c, r0, n;
  logic [11:0]      a_lo [2] = '{{`IDX_CH0_LO, 2'b00}, {`IDX_CH1_LO, 2'b00}};
  logic [11:0]      a_hi [2] = '{{`IDX_CH0_HI, 2'b00}, {`IDX_CH1_HI, 2'b00}};
  logic [11:0]      a_rf [2] = '{{`IDX_CH0_REF, 2'b00}, {`IDX_CH1_REF, 2'b00}};
  int               ivl [8] = '{78, 154, 188, 226, 246, 302, 308, 384};
  logic [22:0]      ad;

  dram_ctl_top i_dram_ctl_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_release_req(bus_release_req), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .dram_ras_n(dram_ras_n), .dram_cas_n(dram_cas_n), .dram_we_n(dram_we_n),
    .dram_addr(dram_addr), .dram_released(dram_released), .self_refresh_on(self_refresh_on));

  // one device model per channel
  for (genvar g = 0; g < 2; g++) begin : g_mem
    dram_dev_model i_dram_dev_model (.pclk(pclk), .presetn(presetn), .ras_n(dram_ras_n[g]),
      .cas_n(dram_cas_n[g]), .we_n(dram_we_n[g]), .addr(dram_addr[g]), .row(m_row[g]), .col(m_col[g]),
      .wr(m_wr[g]), .n_ref(n_ref[g]), .gap(gap[g]), .width(width[g]));
  end

  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // apb transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic e);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(er, e);
  endtask : rdc

  // access on one channel; c counts states to the ack, 61 means none came
  task automatic acc(input int ch, input logic w, input logic [22:0] a);
    @(posedge pclk);
    mem_req[ch] <= 1'b1;
    mem_we[ch] <= w;
    mem_addr[ch] <= a;
    c = 0;
    forever begin
      @(negedge pclk);
      if (mem_ack[ch] === 1'b1 || c > 60) break;
      c++;
    end
    @(posedge pclk);
    mem_req[ch] <= 1'b0;
  endtask : acc

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // ***************************************************************
  // stimulus
  // ***************************************************************
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // hang guard, well beyond the roughly 7k states the tests need
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    $display("BAD t=%0t watchdog got=%h exp=%h", $time, 0, 1);
    close_out;
  end

  initial begin
    {psel, penable, pwrite, bus_release_req, paddr, pwdata} = '0;
    {mem_req, mem_we, mem_addr} = '0;
    {err_count, n_checks} = '0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int ch = 0; ch < 2; ch++) begin
      rdc(a_lo[ch], 32'h80, 1'b0);
      rdc(a_hi[ch], 32'hA0, 1'b0);
      rdc(a_rf[ch], 32'h00, 1'b0);
      wr(a_lo[ch], 32'hFF);
      rdc(a_lo[ch], 32'hAF, 1'b0);
      wr(a_hi[ch], 32'hFF);
      rdc(a_hi[ch], 32'hF8, 1'b0);
      wr(a_rf[ch], 32'h7E);
      rdc(a_rf[ch], 32'h00, 1'b0);
      wr(a_rf[ch], 32'h00);
      wr(a_lo[ch], 32'h80);
    end
    rdc(12'h598, 32'h0, 1'b1);
    rdc(12'h581, 32'h0, 1'b1);
    $display("test registers done");
    // access gate, page waits for every code, address split for every width
    for (int ch = 0; ch < 2; ch++) begin
      acc(ch, 1'b1, 23'h12345);
      chk(c, 61);
      wr(a_lo[ch], 32'h81);
      for (int w = 0; w < 4; w++) begin
        wr(a_hi[ch], 32'((w << 6) | (w << 4)));
        acc(ch, 1'b1, 23'h12345);
        chk(c, (w == 1) ? 4 : 5);
        chk({m_wr[ch], m_col[ch]}, {1'b1, 11'h345});
        acc(ch, 1'b0, 23'h12345);
        chk(c, (w == 1) ? 4 : 5);
        chk({m_wr[ch], m_row[ch]}, {1'b0, 11'h345});
      end
      for (int mw = 0; mw < 4; mw++) begin
        wr(a_lo[ch], 32'h89 | 32'(mw << 1));
        ad = 23'h5A5A5;
        acc(ch, 1'b0, ad);
        chk(m_row[ch], 32'((ad >> (8 + mw)) & 23'h7FF));
        chk(m_col[ch], 32'(ad & ((23'h1 << (8 + mw)) - 1)));
      end
    end
    $display("test access done");
    wr(a_lo[0], 32'h81);
    wr(a_lo[1], 32'hA1);
    @(posedge pclk);
    bus_release_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(dram_released, 2'b01);
    acc(0, 1'b0, 23'h00010);
    chk(c, 61);
    bus_release_req <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(dram_released, 2'b00);
    wr(a_lo[0], 32'h01);
    repeat (4) @(posedge pclk);
    chk({self_refresh_on[0], dram_ras_n[0], dram_cas_n[0]}, 3'b100);
    acc(0, 1'b0, 23'h00010);
    chk(c, 61);
    wr(a_lo[0], 32'h81);
    repeat (4) @(posedge pclk);
    chk(self_refresh_on[0], 1'b0);
    $display("test release and self-refresh done");
    r0 = n_ref[0];
    repeat (500) @(posedge pclk);
    chk(n_ref[0] - r0, 0);
    for (int k = 0; k < 8; k++) begin
      wr(a_rf[0], 32'((k << 4) | (k << 1) | 1));
      r0 = n_ref[0];
      n = 0;
      while (n_ref[0] < r0 + 3 && n < 2000) begin
        @(posedge pclk);
        n++;
      end
      chk(gap[0], ivl[k]);
      chk(width[0], k + 2);
    end
    // accesses racing a short refresh interval
    wr(a_rf[0], 32'h03);
    for (int i = 0; i < 20; i++) begin
      acc(0, 1'b1, 23'(i * 8'h13));
      chk(m_col[0], 32'(i * 8'h13));
      chk(c < 15, 1'b1);
    end
    $display("test refresh done");
    for (int ch = 0; ch < 2; ch++) begin
      wr(a_rf[ch], 32'h00);
      repeat (10) @(posedge pclk);
      r0 = n_ref[ch];
      wr(a_rf[ch], 32'h80);
      repeat (150) @(posedge pclk);
      chk(n_ref[ch] - r0, `DUMMY_COUNT);
    end
    // page hit on channel 1: row stays open, second access skips the row phase
    wr(a_hi[1], 32'h58);
    acc(1, 1'b0, 23'h00100);
    acc(1, 1'b1, 23'h00104);
    chk(c, 3);
    chk({dram_ras_n[1], m_wr[1], m_col[1]}, {1'b0, 1'b1, 11'h104});
    $display("test dummy and page done");
    close_out;
  end
endmodule : dual_channel_dram_control_bench

bind dram_ctl_top dram_ctl_sva i_dram_ctl_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .bus_release_req(bus_release_req), .mem_req(mem_req),
  .mem_ack(mem_ack), .dram_ras_n(dram_ras_n), .dram_cas_n(dram_cas_n), .dram_released(dram_released),
  .self_refresh_on(self_refresh_on));

`default_nettype wire
